// File: rtl/rss_pkg.sv
// Purpose: Shared constants and types for the rotate, minus and skip datapath
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Opcode values are the command encoding written to the command register
`default_nettype none

package rss_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0]  OFF_ACC   = 8'h00;
    localparam logic [7:0]  OFF_MEM   = 8'h04;
    localparam logic [7:0]  OFF_CMD   = 8'h08;
    localparam logic [7:0]  OFF_FLAGS = 8'h0C;
    localparam logic [7:0]  OFF_STATE = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_BIT_LSB = 8;
    localparam int unsigned CMD_IMM_LSB = 16;
    localparam int unsigned FLG_C       = 0;
    localparam int unsigned FLG_HALF    = 1;
    localparam int unsigned FLG_Z       = 2;
    localparam int unsigned FLG_WRAP    = 3;
    localparam int unsigned FLG_SIGN    = 4;
    localparam int unsigned FLG_CHAIN   = 5;
    localparam int unsigned ST_SKIP     = 0;
    localparam int unsigned ST_TO_ACC   = 1;
    localparam int unsigned ST_TO_MEM   = 2;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [7:0] MEM_RST   = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] ALL_ONES  = 8'hFF;

    // Command opcodes
    typedef enum logic [4:0] {
        OP_ROTATE_LEFT                     = 5'h00,
        OP_ROTATE_LEFT_TO_ACCUMULATOR      = 5'h01,
        OP_ROTATE_LEFT_THROUGH_CARRY       = 5'h02,
        OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR  = 5'h03,
        OP_ROTATE_RIGHT                    = 5'h04,
        OP_ROTATE_RIGHT_TO_ACCUMULATOR     = 5'h05,
        OP_ROTATE_RIGHT_THROUGH_CARRY      = 5'h06,
        OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR = 5'h07,
        OP_SUBTRACT_WITH_BORROW            = 5'h08,
        OP_SUBTRACT_BORROW_IMM             = 5'h09,
        OP_SUBTRACT_BORROW_INTO_MEMORY     = 5'h0A,
        OP_MINUS                           = 5'h0B,
        OP_MINUS_IMM                       = 5'h0C,
        OP_MINUS_INTO_MEMORY               = 5'h0D,
        OP_DECREMENT_SKIP_ON_NIL           = 5'h0E,
        OP_DECREMENT_SKIP_TO_ACCUMULATOR   = 5'h0F,
        OP_INCREMENT_SKIP_ON_NIL           = 5'h10,
        OP_INCREMENT_SKIP_TO_ACCUMULATOR   = 5'h11,
        OP_SKIP_ON_BIT_SET                 = 5'h12,
        OP_SKIP_ON_NONZERO                 = 5'h13,
        OP_SET_BYTE                        = 5'h14,
        OP_SET_BIT                         = 5'h15
    } rss_op_e;
    localparam logic [4:0] OP_LAST = 5'h15;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_EXEC  = 3'h2,
        ST_DUMMY = 3'h4
    } rss_state_e;

endpackage

`default_nettype wire

// File: rtl/rss_datapath.sv
// Purpose: Rotate, minus-with-borrow, step-and-skip and set datapath with APB access
// Assumes: APB master on core_clk; software stages the memory byte and accumulator
// Notes:   A command write runs one execute cycle, plus one dummy cycle on a skip
//
// Functional notes
// RULE1: rotate left moves bit 7 to bit 0, no flag changes
// RULE2: rotate left through carry: old carry to bit 0, bit 7 to carry
// RULE3: rotate right moves bit 0 to bit 7, no flag changes
// RULE4: rotate right through carry: old carry to bit 7, bit 0 to carry
// RULE5: accumulator-destination rotates leave the memory byte untouched
// RULE6: borrow minus is accumulator minus operand minus inverted carry
// RULE7: every minus clears carry on negative result, sets it otherwise
// RULE8: every minus updates overflow, zero, half, carry, sign and nil flags
// RULE9: memory-destination minus forms write the difference to memory
// RULE10: plain minus of memory operand stores into the accumulator
// RULE11: immediate plain minus subtracts the command constant from accumulator
// RULE12: immediate borrow minus also subtracts the inverted carry
// RULE13: decrement memory, write back, skip when zero, flags kept
// RULE14: decrement to accumulator keeps memory, skips when accumulator zero
// RULE15: increment memory, write back, skip when it wraps to zero
// RULE16: increment to accumulator keeps memory, skips when accumulator zero
// RULE17: a taken skip adds one dummy cycle
// RULE18: bit test skips when the selected memory bit is one
// RULE19: nonzero test writes the byte back and skips when nonzero
// RULE20: set byte forces memory to all ones, flags kept
// RULE21: set bit forces only the selected bit to one
// RULE22: zero flag is set exactly when the minus result is all zero
//
// The implementer's own choices: register access over APB and the register offsets.
`default_nettype none

module rss_datapath (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [rss_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    output logic [7:0]                     acc,
    output logic [7:0]                     mem_byte,
    output logic [5:0]                     flags,
    output logic                           skip_taken,
    output logic                           dummy_cycle
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_nil(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // ------------------------------------------------------------
    // State and command
    // ------------------------------------------------------------
    rss_pkg::rss_state_e state;
    rss_pkg::rss_state_e next_state;
    rss_pkg::rss_op_e    cur_op;
    logic [2:0]          cur_bit;
    logic [7:0]          cur_imm;
    logic [1:0]          last_dst;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        xfer;
    logic        wr;
    logic        hit_acc;
    logic        hit_mem;
    logic        hit_cmd;
    logic        hit_flags;
    logic        hit_state;
    logic        cmd_legal;
    logic        err_now;
    logic        next_pready;
    logic        start;
    logic        ex;
    logic [31:0] rd_mux;

    // Access completes only on the registered ready edge
    assign xfer      = psel & penable & pready;
    assign wr        = xfer & pwrite;
    assign hit_acc   = paddr == rss_pkg::OFF_ACC;
    assign hit_mem   = paddr == rss_pkg::OFF_MEM;
    assign hit_cmd   = paddr == rss_pkg::OFF_CMD;
    assign hit_flags = paddr == rss_pkg::OFF_FLAGS;
    assign hit_state = paddr == rss_pkg::OFF_STATE;
    assign cmd_legal = pwdata[rss_pkg::CMD_OP_LSB +: 5] <= rss_pkg::OP_LAST;
    assign err_now   = ~(hit_acc | hit_mem | hit_cmd | hit_flags | hit_state)
                     | (hit_cmd & pwrite & ~cmd_legal);
    // Ready is withheld while a command runs, so bus writes never race the datapath
    assign next_pready = psel & penable & ~pready & (state == rss_pkg::ST_IDLE);
    assign start       = wr & hit_cmd & ~pslverr;
    assign ex          = state == rss_pkg::ST_EXEC;

    // Read selection, unused bits read zero
    assign rd_mux = hit_acc   ? {24'h000000, acc} :
                    hit_mem   ? {24'h000000, mem_byte} :
                    hit_cmd   ? {8'h00, cur_imm, 5'h00, cur_bit, 3'h0, cur_op} :
                    hit_flags ? {26'h0000000, flags} :
                    hit_state ? {29'h00000000, last_dst, skip_taken} : 32'h00000000;

    // ------------------------------------------------------------
    // Datapath arithmetic
    // ------------------------------------------------------------
    logic       c_in;
    logic       use_imm;
    logic       use_borrow;
    logic       borrow;
    logic [7:0] operand;
    logic [8:0] diff9;
    logic [4:0] nib5;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic       sgn_wrap;

    assign c_in       = flags[rss_pkg::FLG_C];
    assign use_imm    = cur_op == rss_pkg::OP_SUBTRACT_BORROW_IMM
                      || cur_op == rss_pkg::OP_MINUS_IMM;                       // [RULE11] [RULE12]
    assign use_borrow = cur_op == rss_pkg::OP_SUBTRACT_WITH_BORROW
                      || cur_op == rss_pkg::OP_SUBTRACT_BORROW_IMM
                      || cur_op == rss_pkg::OP_SUBTRACT_BORROW_INTO_MEMORY;
    assign borrow     = use_borrow & ~c_in;                                     // [RULE6] [RULE12]
    assign operand    = use_imm ? cur_imm : mem_byte;
    // Ninth bit is the borrow out; a clear borrow means a non-negative result
    assign diff9      = {1'b0, acc} - {1'b0, operand} - {8'h00, borrow};        // [RULE6] [RULE10]
    assign nib5       = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, borrow};
    assign sgn_wrap   = (acc[7] ^ operand[7]) & (diff9[7] ^ acc[7]);
    assign dec_v      = mem_byte - 8'h01;
    assign inc_v      = mem_byte + 8'h01;

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    logic [7:0] res;
    logic       dst_acc;
    logic       dst_mem;
    logic       skip_hit;
    logic       minus_op;
    logic [5:0] flags_new;

    always_comb
    begin
        res       = mem_byte;
        dst_acc   = 1'b0;
        dst_mem   = 1'b0;
        skip_hit  = 1'b0;
        minus_op  = 1'b0;
        flags_new = flags;
        unique case (cur_op)
            rss_pkg::OP_ROTATE_LEFT, rss_pkg::OP_ROTATE_LEFT_TO_ACCUMULATOR:
            begin
                res     = {mem_byte[6:0], mem_byte[7]};                         // [RULE1]
                dst_acc = cur_op == rss_pkg::OP_ROTATE_LEFT_TO_ACCUMULATOR;     // [RULE5]
                dst_mem = ~dst_acc;
            end
            rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, rss_pkg::OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR:
            begin
                res     = {mem_byte[6:0], c_in};                                // [RULE2]
                flags_new[rss_pkg::FLG_C] = mem_byte[7];
                dst_acc = cur_op == rss_pkg::OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR;
                dst_mem = ~dst_acc;
            end
            rss_pkg::OP_ROTATE_RIGHT, rss_pkg::OP_ROTATE_RIGHT_TO_ACCUMULATOR:
            begin
                res     = {mem_byte[0], mem_byte[7:1]};                         // [RULE3]
                dst_acc = cur_op == rss_pkg::OP_ROTATE_RIGHT_TO_ACCUMULATOR;
                dst_mem = ~dst_acc;
            end
            rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR:
            begin
                res     = {c_in, mem_byte[7:1]};                                // [RULE4]
                flags_new[rss_pkg::FLG_C] = mem_byte[0];
                dst_acc = cur_op == rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR;
                dst_mem = ~dst_acc;
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW, rss_pkg::OP_SUBTRACT_BORROW_IMM,
            rss_pkg::OP_SUBTRACT_BORROW_INTO_MEMORY, rss_pkg::OP_MINUS,
            rss_pkg::OP_MINUS_IMM, rss_pkg::OP_MINUS_INTO_MEMORY:
            begin
                minus_op = 1'b1;
                res      = diff9[7:0];
                dst_mem  = cur_op == rss_pkg::OP_SUBTRACT_BORROW_INTO_MEMORY
                         || cur_op == rss_pkg::OP_MINUS_INTO_MEMORY;            // [RULE9]
                dst_acc  = ~dst_mem;                                            // [RULE10]
                flags_new[rss_pkg::FLG_C]  = ~diff9[8];                         // [RULE7]
                flags_new[rss_pkg::FLG_HALF]  = ~nib5[4];                       // [RULE8]
                flags_new[rss_pkg::FLG_Z]     = is_nil(diff9[7:0]);             // [RULE22]
                flags_new[rss_pkg::FLG_WRAP]  = sgn_wrap;
                flags_new[rss_pkg::FLG_SIGN]  = diff9[7] ^ sgn_wrap;
                // Chained zero: a borrow form only stays nil if the previous step was
                flags_new[rss_pkg::FLG_CHAIN] = is_nil(diff9[7:0])
                                              & (~use_borrow | flags[rss_pkg::FLG_CHAIN]);
            end
            rss_pkg::OP_DECREMENT_SKIP_ON_NIL, rss_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR:
            begin
                res      = dec_v;                                               // [RULE13] [RULE14]
                skip_hit = is_nil(dec_v);
                dst_acc  = cur_op == rss_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR;
                dst_mem  = ~dst_acc;
            end
            rss_pkg::OP_INCREMENT_SKIP_ON_NIL, rss_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR:
            begin
                res      = inc_v;                                               // [RULE15] [RULE16]
                skip_hit = is_nil(inc_v);
                dst_acc  = cur_op == rss_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR;
                dst_mem  = ~dst_acc;
            end
            rss_pkg::OP_SKIP_ON_BIT_SET:
            begin
                skip_hit = mem_byte[cur_bit];                                   // [RULE18]
            end
            rss_pkg::OP_SKIP_ON_NONZERO:
            begin
                skip_hit = ~is_nil(mem_byte);                                   // [RULE19]
                dst_mem  = 1'b1;
            end
            rss_pkg::OP_SET_BYTE:
            begin
                res     = rss_pkg::ALL_ONES;                                    // [RULE20]
                dst_mem = 1'b1;
            end
            rss_pkg::OP_SET_BIT:
            begin
                res          = mem_byte;
                res[cur_bit] = 1'b1;                                            // [RULE21]
                dst_mem      = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A taken skip holds the bus for one extra cycle, mirroring the fetch bubble
    always_comb
    begin
        unique case (state)
            rss_pkg::ST_IDLE:  next_state = start ? rss_pkg::ST_EXEC : rss_pkg::ST_IDLE;
            rss_pkg::ST_EXEC:  next_state = skip_hit ? rss_pkg::ST_DUMMY : rss_pkg::ST_IDLE; // [RULE17]
            rss_pkg::ST_DUMMY: next_state = rss_pkg::ST_IDLE;
            default:           next_state = rss_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            state <= rss_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // Command latch
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            cur_op  <= rss_pkg::OP_ROTATE_LEFT;
            cur_bit <= 3'h0;
            cur_imm <= 8'h00;
        end
        else if (start)
        begin
            cur_op  <= rss_pkg::rss_op_e'(pwdata[rss_pkg::CMD_OP_LSB +: 5]);
            cur_bit <= pwdata[rss_pkg::CMD_BIT_LSB +: 3];
            cur_imm <= pwdata[rss_pkg::CMD_IMM_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // Architectural registers
    // ------------------------------------------------------------
    // Accumulator: bus write or accumulator-destination result
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            acc <= rss_pkg::ACC_RST;
        else if (wr && hit_acc)
            acc <= pwdata[7:0];
        else if (ex && dst_acc)
            acc <= res;                                                         // [RULE5] [RULE14] [RULE16]
    end

    // Memory byte: written back only by memory-destination forms
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            mem_byte <= rss_pkg::MEM_RST;
        else if (wr && hit_mem)
            mem_byte <= pwdata[7:0];
        else if (ex && dst_mem)
            mem_byte <= res;                                                    // [RULE9] [RULE13] [RULE15]
    end

    // Flags change only where an operation says so
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            flags <= rss_pkg::FLAGS_RST;
        else if (wr && hit_flags)
            flags <= pwdata[5:0];
        else if (ex)
            flags <= flags_new;                                                 // [RULE8]
    end

    // Skip result stays readable until the next command
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            skip_taken  <= 1'b0;
            dummy_cycle <= 1'b0;
            last_dst    <= 2'h0;
        end
        else
        begin
            dummy_cycle <= ex & skip_hit;                                       // [RULE17]
            if (ex)
            begin
                skip_taken <= skip_hit;
                last_dst   <= {dst_mem, dst_acc};
            end
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= next_pready;
            prdata  <= (next_pready && !pwrite) ? rd_mux : 32'h00000000;
            pslverr <= next_pready & err_now;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic [8:0] take9;
    assign take9 = {1'b0, operand} + {8'h00, borrow};

    rot_left_a: assert property ( // [RULE1]
        ex && cur_op == rss_pkg::OP_ROTATE_LEFT |=>
        mem_byte == {$past(mem_byte[6:0]), $past(mem_byte[7])} && $stable(flags))
        else $error("rotate left result wrong");

    rot_carry_a: assert property ( // [RULE2]
        ex && cur_op == rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY |=>
        mem_byte[0] == $past(flags[0]) && flags[0] == $past(mem_byte[7])
        && flags[5:1] == $past(flags[5:1]))
        else $error("rotate through carry wrong");

    rot_right_a: assert property ( // [RULE3]
        ex && cur_op == rss_pkg::OP_ROTATE_RIGHT |=>
        mem_byte == {$past(mem_byte[0]), $past(mem_byte[7:1])})
        else $error("rotate right result wrong");

    rot_rcarry_a: assert property ( // [RULE4]
        ex && cur_op == rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR |=>
        acc == {$past(flags[0]), $past(mem_byte[7:1])} && flags[0] == $past(mem_byte[0]))
        else $error("rotate right through carry wrong");

    acc_dest_a: assert property ( // [RULE5]
        ex && dst_acc |=> $stable(mem_byte))
        else $error("memory changed on accumulator form");

    borrow_calc_a: assert property ( // [RULE6]
        ex && cur_op == rss_pkg::OP_SUBTRACT_WITH_BORROW |=>
        acc == 8'($past(acc) - $past(mem_byte) - {7'h00, ~$past(flags[0])}))
        else $error("borrow minus result wrong");

    carry_sign_a: assert property ( // [RULE7]
        ex && minus_op |=> flags[0] == ($past({1'b0, acc}) >= $past(take9)))
        else $error("minus carry wrong");

    mem_dest_a: assert property ( // [RULE9]
        ex && cur_op == rss_pkg::OP_MINUS_INTO_MEMORY |=>
        $stable(acc) && mem_byte == 8'($past(acc) - $past(mem_byte)))
        else $error("memory minus destination wrong");

    zero_flag_a: assert property ( // [RULE22]
        ex && minus_op && dst_acc |=> flags[2] == (acc == 8'h00))
        else $error("zero flag wrong");

    dec_skip_a: assert property ( // [RULE13]
        ex && cur_op == rss_pkg::OP_DECREMENT_SKIP_ON_NIL |=>
        mem_byte == 8'($past(mem_byte) - 8'h01) && skip_taken == (mem_byte == 8'h00)
        && $stable(flags))
        else $error("decrement skip wrong");

    skip_dummy_a: assert property ( // [RULE17]
        ex && skip_hit |=> dummy_cycle && !pready ##1 !dummy_cycle && state == rss_pkg::ST_IDLE)
        else $error("skip dummy cycle wrong");

    bit_skip_a: assert property ( // [RULE18]
        ex && cur_op == rss_pkg::OP_SKIP_ON_BIT_SET |=> skip_taken == $past(mem_byte[cur_bit]))
        else $error("bit test skip wrong");

    set_all_a: assert property ( // [RULE20]
        ex && cur_op == rss_pkg::OP_SET_BYTE |=> mem_byte == 8'hFF && $stable(flags))
        else $error("set byte wrong");

    set_bit_a: assert property ( // [RULE21]
        ex && cur_op == rss_pkg::OP_SET_BIT |=>
        mem_byte == ($past(mem_byte) | (8'h01 << $past(cur_bit))) && $stable(flags))
        else $error("set bit wrong");

    skip_seen_c:  cover property (ex && skip_hit ##1 dummy_cycle);
    minus_neg_c:  cover property (ex && minus_op && diff9[8]);
    rot_carry_c:  cover property (ex && cur_op == rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY && c_in);
    bus_error_c:  cover property (pready && pslverr);

endmodule

`default_nettype wire

// File: tb/rss_mem_model.sv
// Purpose: Reference model of the data memory byte and accumulator
// Assumes: Byte values 0..255, flags 0..63
// Notes:   Flag bit positions follow the package
`default_nettype none
module rss_mem_model;
    timeunit 1ns;
    timeprecision 1ns;
    // One command; b is the subtrahend and w the borrow taken in
    function automatic void step(input int op, bi, im, inout int a, m, f, output int sk);
        int b, w, r, v, o, t;
        b = (op == 9 || op == 12) ? im : m;
        w = (op <= 10) ? 1 - (f & 1) : 0;
        r = a - b - w;
        v = r & 255;
        o = ((a ^ b) & (a ^ v) & 128) != 0;
        case (op)
            0, 1: t = (m << 1 | m >> 7) & 255;
            2, 3: t = (m << 1 | f & 1) & 255;
            4, 5: t = (m >> 1 | m << 7) & 255;
            6, 7: t = m >> 1 | (f & 1) << 7;
            14, 15: t = (m + 255) & 255;
            16, 17: t = (m + 1) & 255;
            20: t = 255;
            21: t = m | 1 << bi;
            default: t = (op >= 8 && op <= 13) ? v : m;
        endcase
        // Only the carry moves on a rotate through carry
        if (op inside {2, 3, 6, 7})
            f = f & 62 | (op < 4 ? m >> 7 : m & 1);
        if (op >= 8 && op <= 13)
            f = (r >= 0) | (a % 16 - b % 16 - w >= 0) << 1 | (v == 0) << 2 | o << 3 | (v >> 7 ^ o) << 4
                | (op <= 10 ? (v == 0) & f >> 5 : v == 0) << 5;
        if (op inside {1, 3, 5, 7, 8, 9, 11, 12, 15, 17})
            a = t;
        else
            m = t;
        sk = (op inside {14, 15, 16, 17}) ? t == 0 : op == 18 ? m >> bi & 1 : op == 19 && m != 0;
    endfunction
endmodule
`default_nettype wire

// File: tb/mcu_rotate_subtract_skip_ops_tb.sv
// Purpose: Self-checking bench for the rotate, minus and skip datapath
// Assumes: APB slave with wait states; expectations from rss_mem_model
// Notes:   Operands from an xorshift seeded at 93
`default_nettype none
module mcu_rotate_subtract_skip_ops_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic pready, pslverr, skip_taken, dummy_cycle;
    logic [7:0] paddr = 8'h00, acc, mem_byte;
    logic [5:0] flags;
    logic [31:0] pwdata = 32'h0, prdata, q, x = 32'h0000005D;
    int n_errors = 0, samples_checked = 0, cyc = 0, n_dummy = 0, n_skips = 0, a, m, f, sk, it, op, da;
    rss_mem_model model ();
    rss_datapath dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc(acc),
        .mem_byte(mem_byte), .flags(flags), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle));
    always #5 core_clk = ~core_clk;
    // Cycle limit, since a slave that never answers would hang the run
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        n_dummy <= n_dummy + int'(dummy_cycle === 1'b1);
        if (cyc == 6000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // Operand source for the command loop
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] s;
        s = v ^ (v << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
            n_errors++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
    endtask
    // One APB transfer, held until pready; answer kept in q and e
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk({acc, mem_byte, 6'h00, pready, pslverr, skip_taken, dummy_cycle, flags}, 32'h0);
        $display("Reset test done");
        for (it = 0; it < 4; it++)
            for (op = 0; op < 22; op++)
            begin
                x = xorshift(x);
                a = x[7:0];
                // Values 1 and 255 make the decrement and increment skips fire
                m = (x[9:8] == 2'h0) ? 1 : (x[9:8] == 2'h1) ? 255 : (x[9:8] == 2'h2) ? 0 : x[17:10];
                f = x[23:18];
                apb(1'b1, rss_pkg::OFF_ACC, a);
                apb(1'b1, rss_pkg::OFF_MEM, m);
                apb(1'b1, rss_pkg::OFF_FLAGS, f);
                apb(1'b1, rss_pkg::OFF_CMD, {8'h00, x[31:24], 5'h00, x[26:24], 3'h0, op[4:0]});
                model.step(op, x[26:24], x[31:24], a, m, f, sk);
                n_skips += sk;
                apb(1'b0, rss_pkg::OFF_STATE, 32'h0);
                da = op inside {1, 3, 5, 7, 8, 9, 11, 12, 15, 17};
                chk(q, {29'h0, op != 18 && da == 0, da[0], sk[0]});
                chk({acc, mem_byte, 2'h0, flags, 7'h00, skip_taken},
                    {a[7:0], m[7:0], 2'h0, f[5:0], 7'h00, sk[0]});
            end
        chk(n_dummy, n_skips);
        $display("Command test done");
        apb(1'b0, rss_pkg::OFF_ACC, 32'h0);
        chk(q, a);
        apb(1'b0, rss_pkg::OFF_MEM, 32'h0);
        chk(q, m);
        apb(1'b0, rss_pkg::OFF_FLAGS, 32'h0);
        chk(q, f);
        apb(1'b0, rss_pkg::OFF_CMD, 32'h0);
        chk(q, {8'h00, x[31:24], 5'h00, x[26:24], 3'h0, 5'h15});
        $display("Readback test done");
        apb(1'b0, 8'h14, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, rss_pkg::OFF_CMD, 32'h16);
        chk({31'h0, e}, 32'h1);
        // A refused command must not run: give it time to show if it did
        repeat (3) @(posedge core_clk);
        chk({acc, mem_byte, 10'h000, flags}, {a[7:0], m[7:0], 10'h000, f[5:0]});
        $display("Refusal test done");
        give_verdict();
    end
endmodule
`default_nettype wire
